// File: hw/dmc_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the mode-control bank
// Assumes: Byte-wide registers at their printed addresses on the serial control port
// Notes: Definitions only
`ifndef DMC_MAP_VH
`define DMC_MAP_VH
// Register addresses
`define DMC_ADDR_RESET_MUTE 7'h40
`define DMC_ADDR_PSAVE_FMT 7'h41
`define DMC_ADDR_PAIR_ROLL 7'h42
`define DMC_ADDR_PHASE 7'h43
`define DMC_ADDR_SOFT_MUTE 7'h44
`define DMC_ADDR_SILENCE 7'h45
// Field positions in the reset and mute-source register
`define DMC_BIT_DEFAULTS 7
`define DMC_BIT_RESYNC 6
`define DMC_ANALOG_MUTE_SOURCES_HI 5
`define DMC_ANALOG_MUTE_SOURCES_LO 2
`define DMC_SRATE_HI 1
`define DMC_SRATE_LO 0
// Field positions in the power-save and format register
`define DMC_BIT_PSAVE 7
`define DMC_FMT_HI 3
`define DMC_FMT_LO 0
// Field positions in the pair register
`define DMC_PAIR_HI 7
`define DMC_PAIR_LO 4
`define DMC_ROLL_HI 3
`define DMC_ROLL_LO 0
// Reset values
`define DMC_RST_ANALOG_MUTE_SOURCES 4'h0
`define DMC_RST_SRATE 2'h0
`define DMC_RST_PSAVE 1'h0
`define DMC_RST_FMT 4'h0
`define DMC_RST_PAIR 4'h0
`define DMC_RST_ROLL 4'h0
`define DMC_RST_PHASE 8'h00
`define DMC_RST_MUTE 8'h00
// Sampling-mode codes
`define DMC_SR_AUTO 2'h0
`define DMC_SR_SINGLE 2'h1
`define DMC_SR_DUAL 2'h2
`define DMC_SR_QUAD 2'h3
// Clock ratio codes given by the clock detector
`define DMC_RATIO_128 3'h0
`define DMC_RATIO_192 3'h1
`define DMC_RATIO_256 3'h2
`define DMC_RATIO_384 3'h3
`define DMC_RATIO_512 3'h4
`define DMC_RATIO_768 3'h5
`define DMC_RATIO_1152 3'h6
// Ramp step spacing in sampling periods
`define DMC_RAMP_PERIODS 4'h8
// Pair output drive codes
`define DMC_DRV_DATA 2'h0
`define DMC_DRV_COMMON_MODE_LEVEL 2'h1
`define DMC_DRV_ANALOG_GROUND 2'h2
`endif

// File: hw/dmc_ramp.v
// Purpose: One channel attenuator level that walks toward its target one step at a time
// Assumes: step_en is a one-cycle pulse per ramp step
// Notes: Level 0 stands for infinite attenuation
`timescale 1ns/100ps
`include "dmc_map.vh"
module dmc_ramp
(
	input wire clk,
	input wire rst_n,
	input wire step_en,
	input wire mute,
	input wire [7:0] target_level,
	output reg [7:0] level_r
);
	// Mute overrides the programmed level; unmute walks back up to it
	wire [7:0] goal;
	assign goal = mute ? 8'h00 : target_level;

	// One step per enable toward the goal
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			level_r <= 8'h00;
		else if (step_en && level_r < goal)
			level_r <= level_r + 8'h01;
		else if (step_en && level_r > goal)
			level_r <= level_r - 8'h01;
	end
endmodule // dmc_ramp

// File: hw/dmc_regs.v
// Purpose: Mode-control register bank of an eight-channel audio DAC
// Assumes: Serial control port delivers decoded one-cycle write and read strobes
// Notes: Core runs on core_clk; fs_tick marks one sampling period
//
// Functional notes
// - Writing 0 to defaults-reload restores all mode registers; bit self-returns to 1.
// - Writing 0 to system-resync restarts DAC, keeps registers, bit self-returns.
// - Four mute-source enables gate clock loss, async, zero flags, disable command.
// - Sample rate mode 00 auto, 01 single, 10 dual, 11 quad.
// - Auto mode picks rate from system to sampling clock ratio.
// - Power-save select 0 makes disable power down; 1 only stops DAC.
// - Four-bit audio format select, codes 101x and 11xx reserved.
// - Each pair-disable bit cuts its pair from input and resets data.
// - Disabled pair drives common-mode when select is 1, else analog ground.
// - Register accesses keep working while any pair is disabled.
// - Roll-off bits pick sharp (0) or slow (1) filter per pair.
// - Output-invert bit n-1 inverts channel n; resets to zero.
// - Soft-mute bit n-1 mutes channel n; resets to zero.
// - Soft mute ramps down to mute and back up to programmed level.
// - Soft mute shares the attenuator and overrides programmed attenuation.
// - Silence status register is read-only, bit n-1 shows channel n zero.
// - Attenuator ramps move one step every 8 sampling periods.
`timescale 1ns/100ps
`include "dmc_map.vh"
module dmc_regs
(
	input wire core_clk,
	input wire reset_n,
	input wire wr_en,
	input wire rd_en,
	input wire [6:0] reg_addr,
	input wire [7:0] wr_data,
	output reg [7:0] rd_data_r,
	input wire fs_tick,
	input wire [2:0] clock_ratio,
	input wire clock_lost,
	input wire async_detect,
	input wire [1:0] zero_pair_flags,
	input wire [7:0] zero_detect,
	input wire [63:0] atten_level,
	output reg system_resync_r,
	output reg [1:0] active_rate_r,
	output wire [1:0] sample_rate_mode,
	output wire [3:0] audio_format_select,
	output wire format_reserved,
	output wire power_save_select,
	output wire [3:0] pair_disable,
	output reg [7:0] pair_drive_r,
	output reg [3:0] pair_power_down_r,
	output wire [3:0] rolloff_select,
	output wire [7:0] output_invert,
	output wire [7:0] channel_soft_mute,
	output reg analog_mute_r,
	output wire [63:0] channel_level
);
	// Reset release through two flip-flops
	reg rst_meta_r;
	reg rst_sync_r;
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Pin inputs through two flip-flops before use
	reg [2:0] ratio_meta_r;
	reg [2:0] ratio_r;
	reg [3:0] evt_meta_r;
	reg [3:0] evt_r;
	reg [7:0] zero_meta_r;
	reg [7:0] zero_r;
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			// Idle as 512 fs, so no false quad rate shows right after reset
			ratio_meta_r <= `DMC_RATIO_512;
			ratio_r <= `DMC_RATIO_512;
			evt_meta_r <= 4'h0;
			evt_r <= 4'h0;
			zero_meta_r <= 8'h00;
			zero_r <= 8'h00;
		end
		else
		begin
			ratio_meta_r <= clock_ratio;
			ratio_r <= ratio_meta_r;
			evt_meta_r <= {zero_pair_flags, async_detect, clock_lost};
			evt_r <= evt_meta_r;
			zero_meta_r <= zero_detect;
			zero_r <= zero_meta_r;
		end
	end

	// Address decode shared by read and write paths
	function [5:0] dmc_decode;
		input [6:0] addr;
		begin
			dmc_decode = 6'h00;
			case (addr)
				`DMC_ADDR_RESET_MUTE: dmc_decode = 6'h01;
				`DMC_ADDR_PSAVE_FMT: dmc_decode = 6'h02;
				`DMC_ADDR_PAIR_ROLL: dmc_decode = 6'h04;
				`DMC_ADDR_PHASE: dmc_decode = 6'h08;
				`DMC_ADDR_SOFT_MUTE: dmc_decode = 6'h10;
				`DMC_ADDR_SILENCE: dmc_decode = 6'h20;
				default: dmc_decode = 6'h00;
			endcase
		end
	endfunction

	// Strobes gate the decode so a stray address alone never selects a register
	wire [5:0] wr_sel;
	wire [5:0] rd_sel;
	assign wr_sel = wr_en ? dmc_decode(reg_addr) : 6'h00;
	assign rd_sel = rd_en ? dmc_decode(reg_addr) : 6'h00;

	wire reload;
	assign reload = wr_sel[0] && !wr_data[`DMC_BIT_DEFAULTS];

	// Mode fields
	reg [3:0] analog_mute_sources_r;
	reg [1:0] srate_r;
	reg psave_r;
	reg [3:0] fmt_r;
	reg [3:0] pair_r;
	reg [3:0] roll_r;
	reg [7:0] phase_r;
	reg [7:0] mute_r;

	// Register writes; keeps them open regardless of pair disable
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			analog_mute_sources_r <= `DMC_RST_ANALOG_MUTE_SOURCES;
			srate_r <= `DMC_RST_SRATE;
			psave_r <= `DMC_RST_PSAVE;
			fmt_r <= `DMC_RST_FMT;
			pair_r <= `DMC_RST_PAIR;
			roll_r <= `DMC_RST_ROLL;
			phase_r <= `DMC_RST_PHASE;
			mute_r <= `DMC_RST_MUTE;
		end
		// whole bank back to defaults, same write ignored
		else if (reload)
		begin
			analog_mute_sources_r <= `DMC_RST_ANALOG_MUTE_SOURCES;
			srate_r <= `DMC_RST_SRATE;
			psave_r <= `DMC_RST_PSAVE;
			fmt_r <= `DMC_RST_FMT;
			pair_r <= `DMC_RST_PAIR;
			roll_r <= `DMC_RST_ROLL;
			phase_r <= `DMC_RST_PHASE;
			mute_r <= `DMC_RST_MUTE;
		end
		else
		begin
			if (wr_sel[0])
			begin
				analog_mute_sources_r <= wr_data[`DMC_ANALOG_MUTE_SOURCES_HI:`DMC_ANALOG_MUTE_SOURCES_LO];
				srate_r <= wr_data[`DMC_SRATE_HI:`DMC_SRATE_LO];
			end
			if (wr_sel[1])
			begin
				psave_r <= wr_data[`DMC_BIT_PSAVE];
				fmt_r <= wr_data[`DMC_FMT_HI:`DMC_FMT_LO];
			end
			if (wr_sel[2])
			begin
				pair_r <= wr_data[`DMC_PAIR_HI:`DMC_PAIR_LO];
				roll_r <= wr_data[`DMC_ROLL_HI:`DMC_ROLL_LO];
			end
			if (wr_sel[3])
				phase_r <= wr_data;
			if (wr_sel[4])
				mute_r <= wr_data;
		end
	end

	// resync pulse on a written 0; writing 1 does nothing
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			system_resync_r <= 1'b0;
		else
			system_resync_r <= wr_sel[0] && wr_data[`DMC_BIT_RESYNC] == 1'b0;
	end

	// Readback; reset bits always read 1, status read-only
	// Unmapped addresses read zero rather than stale data
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			rd_data_r <= 8'h00;
		else if (rd_en)
		begin
			case (rd_sel)
				6'h01: rd_data_r <= {2'h3, analog_mute_sources_r, srate_r};
				6'h02: rd_data_r <= {psave_r, 3'h0, fmt_r};
				6'h04: rd_data_r <= {pair_r, roll_r};
				6'h08: rd_data_r <= phase_r;
				6'h10: rd_data_r <= mute_r;
				6'h20: rd_data_r <= zero_r;
				default: rd_data_r <= 8'h00;
			endcase
		end
	end

	// fields straight to the data path
	assign sample_rate_mode = srate_r;
	assign audio_format_select = fmt_r;
	// reserved codes flagged by a flop written beside the field itself
	reg fmt_rsv_r;
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			fmt_rsv_r <= 1'b0;
		else if (reload)
			fmt_rsv_r <= 1'b0;
		else if (wr_sel[1])
			fmt_rsv_r <= wr_data[`DMC_FMT_HI] &&
				(wr_data[`DMC_FMT_HI - 1] || wr_data[`DMC_FMT_HI - 2]);
	end
	assign format_reserved = fmt_rsv_r;
	assign power_save_select = psave_r;
	// pair cut from its input while its bit is set
	assign pair_disable = pair_r;
	assign rolloff_select = roll_r;
	assign output_invert = phase_r;
	assign channel_soft_mute = mute_r;

	// automatic rate from the clock ratio
	reg [1:0] auto_rate;
	always @*
	begin
		case (ratio_r)
			`DMC_RATIO_128, `DMC_RATIO_192: auto_rate = `DMC_SR_QUAD;
			`DMC_RATIO_256, `DMC_RATIO_384: auto_rate = `DMC_SR_DUAL;
			default: auto_rate = `DMC_SR_SINGLE;
		endcase
	end

	// explicit mode wins over automatic choice
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			active_rate_r <= `DMC_SR_SINGLE;
		else if (srate_r == `DMC_SR_AUTO)
			active_rate_r <= auto_rate;
		else
			active_rate_r <= srate_r;
	end

	// per-pair output drive and power down, decoded per pair
	wire [7:0] pair_drive_nxt;
	wire [3:0] pair_down_nxt;
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1)
		begin : g_pair
			assign pair_drive_nxt[2*p+1:2*p] = !pair_r[p] ? `DMC_DRV_DATA :
				(psave_r ? `DMC_DRV_COMMON_MODE_LEVEL : `DMC_DRV_ANALOG_GROUND);
			assign pair_down_nxt[p] = pair_r[p] && !psave_r;
		end
	endgenerate

	// One process owns both outputs, so each has a single driver
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			pair_drive_r <= {4{`DMC_DRV_DATA}};
			pair_power_down_r <= 4'h0;
		end
		else
		begin
			pair_drive_r <= pair_drive_nxt;
			pair_power_down_r <= pair_down_nxt;
		end
	end

	// gated analog mute sources
	// Registered so a glitching source never chatters the mute line
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			analog_mute_r <= 1'b0;
		else
			analog_mute_r <= (analog_mute_sources_r[0] && evt_r[0]) || (analog_mute_sources_r[1] && evt_r[1]) ||
				(analog_mute_sources_r[2] && evt_r[2] && evt_r[3]) || (analog_mute_sources_r[3] && (|pair_r));
	end

	// step enable every eight sampling periods
	// Counted in fs_tick pulses so the ramp needs no second clock
	reg [3:0] fs_cnt_r;
	reg step_r;
	always @(posedge core_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			fs_cnt_r <= 4'h0;
			step_r <= 1'b0;
		end
		else if (fs_tick)
		begin
			fs_cnt_r <= (fs_cnt_r == `DMC_RAMP_PERIODS - 4'h1) ? 4'h0 : fs_cnt_r + 4'h1;
			step_r <= (fs_cnt_r == `DMC_RAMP_PERIODS - 4'h1);
		end
		else
			step_r <= 1'b0;
	end

	// one shared attenuator ramp per channel, mute has priority
	genvar c;
	generate
		for (c = 0; c < 8; c = c + 1)
		begin : g_chan
			dmc_ramp u_ramp
			(
				.clk(core_clk),
				.rst_n(rst_sync_r),
				.step_en(step_r),
				.mute(mute_r[c]),
				.target_level(atten_level[8*c+7:8*c]),
				.level_r(channel_level[8*c+7:8*c])
			);
		end
	endgenerate
endmodule // dmc_regs

// File: sim/dmc_host.sv
// Purpose: Host side of the serial control port as decoded strobes
// Assumes: The bank samples strobes on the rising edge
// Notes: Released lines show the inverse of the last value
`timescale 1ns/100ps
module dmc_host
(
	input wire clk,
	input wire [7:0] rd_data,
	output reg wr_en,
	output reg rd_en,
	output reg [6:0] reg_addr,
	output reg [7:0] wr_data
);
	initial {wr_en, rd_en, reg_addr, wr_data} = '0;
	// One strobe, held to its sampling edge; inverting after hides stale data
	// reserved codes written in the format sweep and the readback table
	task xfer(input w, input [6:0] a, input [7:0] d, output [7:0] q);
	begin
		@(posedge clk);
		wr_en <= w;
		rd_en <= !w;
		reg_addr <= a;
		wr_data <= d;
		@(posedge clk);
		{wr_en, rd_en} <= 2'h0;
		reg_addr <= ~a;
		wr_data <= ~d;
		#1 q = rd_data;
	end
	endtask
endmodule // dmc_host

// File: sim/dmc_regs_checker.sv
// Purpose: Port checks of the mode-control bank
// Assumes: One-cycle strobes on core_clk
// Notes: Bound into every dmc_regs instance
`timescale 1ns/100ps
module dmc_regs_checker
(
	input wire core_clk,
	input wire reset_n,
	input wire wr_en,
	input wire rd_en,
	input wire [6:0] reg_addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_data_r,
	input wire [7:0] zero_detect,
	input wire system_resync_r,
	input wire [1:0] sample_rate_mode,
	input wire [3:0] audio_format_select,
	input wire power_save_select,
	input wire [3:0] pair_disable,
	input wire [7:0] pair_drive_r,
	input wire [3:0] pair_power_down_r,
	input wire [3:0] rolloff_select,
	input wire [7:0] output_invert,
	input wire [7:0] channel_soft_mute
);
	reg resync_req_r;
	// Write decode, bit k for address 0x40+k; out-of-range shifts give zero
	wire [7:0] hit = wr_en ? (8'h01 << (reg_addr - 7'h40)) : 8'h00;
	// Resync request seen at the port, so the pulse can be tied to its cause
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			resync_req_r <= 1'b0;
		else
			resync_req_r <= hit[0] && !wr_data[6];
	end
	default clocking dmc_cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_one_pulse;
		system_resync_r ##1 !system_resync_r;
	endsequence
	a_resync_one_pulse: assert property (resync_req_r |-> s_one_pulse)
		else $error("resync pulse missing");
	a_resync_no_cause: assert property (!resync_req_r |-> !system_resync_r)
		else $error("resync without request");
	a_reload_clears_all: assert property (hit[0] && !wr_data[7] |=>
		{sample_rate_mode, audio_format_select, power_save_select, pair_disable,
		rolloff_select, output_invert, channel_soft_mute} == 31'h0)
		else $error("reload left a field set");
	a_format_write: assert property (hit[1] |=>
		{power_save_select, 3'h0, audio_format_select} == ($past(wr_data) & 8'h8f))
		else $error("format register wrong");
	a_pair_write: assert property (hit[2] |=> {pair_disable, rolloff_select} == $past(wr_data))
		else $error("pair register wrong");
	a_invert_write: assert property (hit[3] |=> output_invert == $past(wr_data))
		else $error("invert register wrong");
	a_mute_write: assert property (hit[4] |=> channel_soft_mute == $past(wr_data))
		else $error("soft mute register wrong");
	a_status_read: assert property (rd_en && reg_addr == 7'h45 |=>
		rd_data_r == $past(zero_detect, 3))
		else $error("status read wrong");
	a_drive_ground: assert property (pair_disable[0] && !power_save_select |=>
		pair_drive_r[1:0] == 2'h2 && pair_power_down_r[0])
		else $error("pair not grounded");
	a_drive_common: assert property (pair_disable[0] && power_save_select |=>
		pair_drive_r[1:0] == 2'h1 && !pair_power_down_r[0])
		else $error("pair not at common mode");
endmodule // dmc_regs_checker
bind dmc_regs dmc_regs_checker chk_u (.*);

// File: sim/tb_dmc_regs.sv
// Purpose: Self-checking bench of the mode-control bank
// Assumes: fs_tick every 4 clocks, so one ramp step takes 32 clocks
// Notes: Mute-source inputs are driven only in the analog mute source test
`timescale 1ns/100ps
module tb_dmc_regs;
	logic core_clk = 1'b0, reset_n = 1'b0, fs_tick = 1'b0;
	logic [1:0] fs_cnt = 2'h0;
	logic [2:0] clock_ratio = 3'h4;
	logic [7:0] zero_detect = 8'h81, rdv, v;
	logic [63:0] atten_level = {8{8'h04}};
	logic [3:0] mute_evt = 4'h0, m;
	wire wr_en, rd_en, system_resync_r, format_reserved, power_save_select, analog_mute_r;
	wire [6:0] reg_addr;
	wire [7:0] wr_data, rd_data_r, pair_drive_r, output_invert, channel_soft_mute;
	wire [1:0] active_rate_r, sample_rate_mode;
	wire [3:0] audio_format_select, pair_disable, pair_power_down_r, rolloff_select;
	wire [63:0] channel_level;
	int err_count = 0, checked = 0, cyc = 0, i, n;
	logic [23:0] rows [8] = '{24'h40c9c9, 24'h41ff8f, 24'h410909, 24'h42a5a5,
		24'h435a5a, 24'h448080, 24'h503300, 24'h450081};
	dmc_host host_u (.clk(core_clk), .rd_data(rd_data_r), .wr_en(wr_en), .rd_en(rd_en),
		.reg_addr(reg_addr), .wr_data(wr_data));
	dmc_regs dut_u (.core_clk(core_clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
		.reg_addr(reg_addr), .wr_data(wr_data), .rd_data_r(rd_data_r), .fs_tick(fs_tick),
		.clock_ratio(clock_ratio), .clock_lost(mute_evt[0]), .async_detect(mute_evt[1]),
		.zero_pair_flags(mute_evt[3:2]), .zero_detect(zero_detect), .atten_level(atten_level),
		.system_resync_r(system_resync_r), .active_rate_r(active_rate_r),
		.sample_rate_mode(sample_rate_mode), .audio_format_select(audio_format_select),
		.format_reserved(format_reserved), .power_save_select(power_save_select),
		.pair_disable(pair_disable), .pair_drive_r(pair_drive_r),
		.pair_power_down_r(pair_power_down_r), .rolloff_select(rolloff_select),
		.output_invert(output_invert), .channel_soft_mute(channel_soft_mute),
		.analog_mute_r(analog_mute_r), .channel_level(channel_level));
	// Clock, sampling tick, and a hang limit far above the run length
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		fs_cnt <= fs_cnt + 2'h1;
		fs_tick <= fs_cnt == 2'h3;
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			final_report;
		end
	end
	task wr(input [6:0] a, input [7:0] d);
		host_u.xfer(1'b1, a, d, rdv);
	endtask
	task rd(input [6:0] a);
		host_u.xfer(1'b0, a, 8'h00, rdv);
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
	begin
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	// Counts the clocks until channel 1 level moves, at most 40
	task gap;
	begin
		v = channel_level[7:0];
		n = 0;
		while (channel_level[7:0] === v && n < 40)
		begin
			@(posedge core_clk);
			#1 n++;
		end
	end
	endtask
	task final_report;
	begin
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 6; i++)
		begin
			rd(7'h40 + i[6:0]);
			chk("reset value", i == 0 ? 8'hc0 : (i == 5 ? 8'h81 : 8'h00), rdv);
		end
		chk("auto 512", 8'h01, {6'h0, active_rate_r});
		for (i = 0; i < 2; i++)
		begin
			@(posedge core_clk);
			clock_ratio <= i == 0 ? 3'h2 : 3'h0;
			repeat (5) @(posedge core_clk);
			chk("auto rate", 8'h02 + i[7:0], {6'h0, active_rate_r});
		end
		$display("test reset and auto rate done");
		repeat (200) @(posedge core_clk);
		wr(7'h44, 8'h01);
		gap;
		gap;
		chk("step gap", 8'h20, n[7:0]);
		repeat (150) @(posedge core_clk);
		chk("muted level", 8'h00, channel_level[7:0]);
		chk("other level", 8'h04, channel_level[15:8]);
		wr(7'h44, 8'h00);
		repeat (170) @(posedge core_clk);
		chk("restored level", 8'h04, channel_level[7:0]);
		$display("test soft mute ramp done");
		foreach (rows[k])
		begin
			wr(rows[k][22:16], rows[k][15:8]);
			rd(rows[k][22:16]);
			chk("readback", rows[k][7:0], rdv);
		end
		for (i = 0; i < 16; i++)
		begin
			wr(7'h41, i[7:0]);
			chk("format", i[7:0], {4'h0, audio_format_select});
			chk("format reserved", {7'h0, i > 9}, {7'h0, format_reserved});
		end
		for (i = 1; i < 4; i++)
		begin
			wr(7'h40, 8'hc0 | i[7:0]);
			repeat (4) @(posedge core_clk);
			chk("forced rate", i[7:0], {6'h0, active_rate_r});
		end
		$display("test register table done");
		wr(7'h42, 8'h5a);
		wr(7'h40, 8'h7f);
		chk("cleared", 8'h00, {7'h0, |{sample_rate_mode, pair_disable, rolloff_select}});
		rd(7'h40);
		chk("reload reads", 8'hc0, rdv);
		wr(7'h43, 8'h5a);
		wr(7'h40, 8'hbf);
		chk("resync", 8'h01, {7'h0, system_resync_r});
		chk("kept", 8'h5a, output_invert);
		wr(7'h40, 8'hc0);
		chk("no resync", 8'h00, {7'h0, system_resync_r});
		wr(7'h42, 8'h10);
		repeat (3) @(posedge core_clk);
		chk("ground drive", 8'h02, pair_drive_r);
		chk("power down", 8'h01, {4'h0, pair_power_down_r});
		wr(7'h41, 8'h80);
		repeat (3) @(posedge core_clk);
		chk("common drive", 8'h01, pair_drive_r);
		rd(7'h42);
		chk("access while off", 8'h10, rdv);
		wr(7'h40, 8'he0);
		repeat (5) @(posedge core_clk);
		chk("analog mute", 8'h01, {7'h0, analog_mute_r});
		wr(7'h40, 8'hc0);
		repeat (5) @(posedge core_clk);
		chk("mute gated", 8'h00, {7'h0, analog_mute_r});
		// Each source counts only through its own enable; one zero flag is not enough
		for (i = 0; i < 3; i++)
		begin
			m = (i == 2) ? 4'hc : 4'h1 << i;
			wr(7'h40, 8'hc0 | (8'h04 << i));
			@(posedge core_clk);
			mute_evt <= ~m | 4'h4;
			repeat (5) @(posedge core_clk);
			chk("source gated", 8'h00, {7'h0, analog_mute_r});
			mute_evt <= m;
			repeat (5) @(posedge core_clk);
			chk("source mute", 8'h01, {7'h0, analog_mute_r});
			mute_evt <= 4'h0;
		end
		$display("test reload resync and disable done");
		final_report;
	end
endmodule // tb_dmc_regs
